// *** core/ncop_map.vh ***
// ncop_map.vh: register offsets, reset values and field widths of the oscillator preset block
// assumes: included by the design files of the ncop block only
`ifndef NCOP_MAP_VH
`define NCOP_MAP_VH

// ********************************
// register byte offsets
// ********************************
`define NCOP_OFS_FREQ0 12'h220
`define NCOP_OFS_PHASE0 12'h224
`define NCOP_OFS_FREQ1 12'h228
`define NCOP_OFS_PHASE1 12'h22C
`define NCOP_OFS_FREQ2 12'h230
`define NCOP_OFS_PHASE2 12'h234
`define NCOP_OFS_FREQ3 12'h238
`define NCOP_OFS_RDIV 12'h240
`define NCOP_OFS_CTRL 12'h244
`define NCOP_OFS_STAT 12'h248

// ********************************
// reset values and widths
// ********************************
`define NCOP_FREQ_RST 32'hC0000000
`define NCOP_PHASE_RST 16'h0000
`define NCOP_RDIV_RST 16'h0000
`define NCOP_CTRL_RST 2'h0
`define NCOP_PRESETS 4
`define NCOP_PHASED 3
`define NCOP_STRIDE 8
`define NCOP_PHASE_SHIFT 16

// ********************************
// control register fields
// ********************************
`define NCOP_CTRL_SINGLE 0
`define NCOP_CTRL_SYNC 1

`endif

// *** core/ncop_preset_mem.v ***
// ncop_preset_mem.v: four frequency words and three phase offsets, registered readback
// assumes: one clock pclk, asynchronous active low reset, writes already decoded
`include "ncop_map.vh"

module ncop_preset_mem (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// write port
	input wire wr_en,
	input wire wr_phase,
	input wire [1:0] wr_idx,
	input wire [31:0] wr_data,
	// readback port, one cycle latency
	input wire [1:0] rd_idx,
	input wire rd_phase,
	output reg [31:0] rd_data,
	// live selection for the datapath
	input wire [1:0] sel_idx,
	output wire [31:0] sel_freq,
	output wire [15:0] sel_phase
);

	wire [31:0] freq_flat [0:`NCOP_PRESETS-1];
	wire [15:0] phase_flat [0:`NCOP_PRESETS-1];

	// ********************************
	// storage, one generate per preset
	// ********************************
	genvar gi;
	generate
		for (gi = 0; gi < `NCOP_PRESETS; gi = gi + 1) begin : g_preset
			reg [31:0] freq_reg;
			reg [15:0] phase_reg;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					freq_reg <= `NCOP_FREQ_RST;
					phase_reg <= `NCOP_PHASE_RST;
				end else if (wr_en && wr_idx == gi) begin
					if (!wr_phase)
						freq_reg <= wr_data;
					else if (gi < `NCOP_PHASED)
						phase_reg <= wr_data[15:0];
				end
			end
			assign freq_flat[gi] = freq_reg;
			// preset 3 has no phase register: its offset stays zero
			assign phase_flat[gi] = (gi < `NCOP_PHASED) ? phase_reg : 16'h0000;
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_data <= 32'h00000000;
		else if (rd_phase)
			rd_data <= {16'h0000, phase_flat[rd_idx]};
		else
			rd_data <= freq_flat[rd_idx];
	end

	assign sel_freq = freq_flat[sel_idx];
	assign sel_phase = phase_flat[sel_idx];

endmodule // ncop_preset_mem

// *** core/ncop_top.v ***
// ncop_top.v: channel A oscillator presets, phase accumulator and phase adder behind APB
// assumes: pclk is the sample clock, sample_en marks one sample per pulse, APB master
//
// Added by the designer: register access over APB.
`include "ncop_map.vh"

module ncop_top (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// sample side
	input wire sample_en,
	input wire [1:0] preset_sel,
	input wire sync_pulse,
	// oscillator outputs
	output reg [31:0] phase_out,
	output reg [31:0] accum_out,
	output wire single_chan
);

	// ********************************
	// address decode
	// ********************************
	wire setup_ok;
	wire in_preset;
	wire [3:0] word_idx;
	wire hit_rdiv;
	wire hit_ctrl;
	wire hit_stat;
	wire mapped;
	wire wr_access;
	wire rd_setup;

	assign in_preset = (paddr >= `NCOP_OFS_FREQ0) && (paddr <= `NCOP_OFS_FREQ3)
		&& (paddr[1:0] == 2'b00);
	wire [11:0] rel_addr;
	assign rel_addr = paddr - `NCOP_OFS_FREQ0;
	assign word_idx = rel_addr[5:2];
	assign hit_rdiv = (paddr == `NCOP_OFS_RDIV);
	assign hit_ctrl = (paddr == `NCOP_OFS_CTRL);
	assign hit_stat = (paddr == `NCOP_OFS_STAT);
	// preset 3 phase slot (offset 23C) is outside this block, so it stays unmapped
	assign mapped = in_preset || hit_rdiv || hit_ctrl || hit_stat;
	assign setup_ok = psel && !penable;
	assign wr_access = psel && penable && pwrite && mapped;
	assign rd_setup = setup_ok && !pwrite;

	// no wait states: read data is registered at the setup edge, so access can end at once
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ********************************
	// control registers
	// ********************************
	reg [15:0] rdiv_reg;
	reg [1:0] ctrl_reg;
	reg [1:0] sel_reg;
	reg resync_reg;
	reg [31:0] misc_rd_reg;
	reg misc_sel_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdiv_reg <= `NCOP_RDIV_RST;
			ctrl_reg <= `NCOP_CTRL_RST;
		end else if (wr_access) begin
			if (hit_rdiv)
				rdiv_reg <= pwdata[15:0];
			if (hit_ctrl)
				ctrl_reg <= pwdata[1:0];
		end
	end

	assign single_chan = ctrl_reg[`NCOP_CTRL_SINGLE];

	// ********************************
	// preset storage
	// ********************************
	wire [31:0] mem_rd;
	wire [31:0] sel_freq;
	wire [15:0] sel_phase;

	ncop_preset_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_access && in_preset),
		.wr_phase(word_idx[0]),
		.wr_idx(word_idx[2:1]),
		.wr_data(pwdata),
		.rd_idx(word_idx[2:1]),
		.rd_phase(word_idx[0]),
		.rd_data(mem_rd),
		.sel_idx(sel_reg),
		.sel_freq(sel_freq),
		.sel_phase(sel_phase)
	);

	// ********************************
	// readback mux
	// ********************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_rd_reg <= 32'h00000000;
			misc_sel_reg <= 1'b0;
		end else if (rd_setup) begin
			misc_sel_reg <= !in_preset;
			if (hit_rdiv)
				misc_rd_reg <= {16'h0000, rdiv_reg};
			else if (hit_ctrl)
				misc_rd_reg <= {30'h00000000, ctrl_reg};
			else if (hit_stat)
				misc_rd_reg <= {29'h00000000, resync_reg, sel_reg};
			else
				misc_rd_reg <= 32'h00000000;
		end
	end

	assign prdata = (psel && penable && !pwrite && mapped)
		? (misc_sel_reg ? misc_rd_reg : mem_rd) : 32'h00000000;

	// ********************************
	// phase accumulator and adder
	// ********************************
	reg [31:0] accum_reg;
	wire [31:0] accum_next;
	wire [31:0] phase_word;
	wire freq_write;

	// a frequency word rewrite clears the synchronised state; sync wins in the same cycle
	assign freq_write = wr_access && in_preset && !word_idx[0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			resync_reg <= 1'b0;
		else if (sync_pulse && ctrl_reg[`NCOP_CTRL_SYNC])
			resync_reg <= 1'b1;
		else if (freq_write)
			resync_reg <= 1'b0;
	end

	// modulo 2^32 sum makes signed and unsigned words identical
	assign accum_next = accum_reg + sel_freq;
	assign phase_word = {sel_phase, 16'h0000};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accum_reg <= 32'h00000000;
			sel_reg <= 2'h0;
			accum_out <= 32'h00000000;
			phase_out <= 32'h00000000;
		end else begin
			// select is taken per sample so a change never splits a sample
			if (sample_en)
				sel_reg <= preset_sel;
			if (sync_pulse && ctrl_reg[`NCOP_CTRL_SYNC])
				accum_reg <= 32'h00000000;
			else if (sample_en)
				accum_reg <= accum_next;
			accum_out <= accum_reg;
			phase_out <= accum_reg + phase_word;
		end
	end

	// divisor is held for the fractional datapath outside this block; zero means off
	wire rdiv_active;
	assign rdiv_active = (rdiv_reg != `NCOP_RDIV_RST);
	wire unused_ok;
	assign unused_ok = rdiv_active;

endmodule // ncop_top

// *** tb/ncop_top_assertions.sv ***
// ncop_top_assertions.sv: port checks for the oscillator preset block
// assumes: bound to ncop_top, one clock pclk, async low reset
module ncop_chk (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// oscillator
	input wire sample_en,
	input wire sync_pulse,
	input wire [31:0] phase_out,
	input wire [31:0] accum_out,
	input wire single_chan
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// checks
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg sync_en_reg;
	sequence ctrl_wr;
		psel && penable && pwrite && paddr == 12'h244;
	endsequence
	// shadow of the sync enable bit, needed to know when a pulse must clear
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			sync_en_reg <= 1'h0;
		else if (psel && penable && pwrite && paddr == 12'h244)
			sync_en_reg <= pwdata[1];
	rdy_high_a: assert property (pready) else $error("pready low");
	hole_err_a: assert property (psel && penable && paddr == 12'h23C |-> pslverr)
		else $error("no error on unmapped slot");
	err_idle_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
	rd_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
		else $error("prdata outside read");
	hold_acc_a: assert property ((!sample_en && !sync_pulse)[*2] |=> $stable(accum_out))
		else $error("accumulator moved without sample");
	phase_lo_a: assert property (phase_out[15:0] == accum_out[15:0])
		else $error("offset not left justified");
	mode_flag_a: assert property (ctrl_wr |=> single_chan == $past(pwdata[0]))
		else $error("single channel flag wrong");
	sync_clr_a: assert property (sync_pulse && sync_en_reg |=> ##1 accum_out == 32'h0)
		else $error("sync did not clear");
endmodule // ncop_chk

bind ncop_top ncop_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sample_en(sample_en), .sync_pulse(sync_pulse),
	.phase_out(phase_out), .accum_out(accum_out), .single_chan(single_chan));

// *** tb/ncop_top_tb.sv ***
// ncop_top_tb.sv: self-checking bench for the oscillator preset block
// assumes: checker bound separately, pclk at 10 MHz
module ncop_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// bench
	// ****
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_en = 0, sync_pulse = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, q;
	logic [1:0] preset_sel = 2'h0;
	logic e;
	wire [31:0] prdata, phase_out, accum_out;
	wire pready, pslverr, single_chan;
	int err_total = 0, checked = 0;
	always #50 pclk = ~pclk;
	ncop_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_en(sample_en), .preset_sel(preset_sel),
		.sync_pulse(sync_pulse), .phase_out(phase_out), .accum_out(accum_out),
		.single_chan(single_chan));
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one setup and one access phase; hold until pready is seen high
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk("wait states", 32'h1, 32'(n));
		// idle edge so a following call never reassigns psel in this time step
		@(posedge pclk);
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk($sformatf("reg %h", a), exp, q);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 7; i++)
			rd(12'h220 + 12'(4 * i), i % 2 ? 32'h0 : 32'hC0000000);
	endtask
	task automatic t_rw;
		for (int i = 0; i < 7; i++) begin
			apb(1'h1, 12'h220 + 12'(4 * i), 32'hA5A55A5A ^ 32'(i));
			rd(12'h220 + 12'(4 * i), (32'hA5A55A5A ^ 32'(i)) & (i % 2 ? 32'hFFFF : '1));
		end
		apb(1'h1, 12'h23C, 32'hFFFF);
		chk("hole err", 32'h1, {31'h0, e});
		rd(12'h23C, 32'h0);
	endtask
	task automatic t_osc;
		apb(1'h1, 12'h220, 32'hFFFFFFFF);
		apb(1'h1, 12'h228, 32'h3);
		apb(1'h1, 12'h22C, 32'h4000);
		sample_en <= 1'h1;
		preset_sel <= 2'h1;
		repeat (2) @(posedge pclk);
		sample_en <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("accum", 32'h2, accum_out);
		chk("phase", 32'h40000002, phase_out);
		apb(1'h1, 12'h244, 32'h3);
		sync_pulse <= 1'h1;
		@(posedge pclk);
		sync_pulse <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("synced accum", 32'h0, accum_out);
		chk("single", 32'h1, {31'h0, single_chan});
		rd(12'h248, 32'h5);
		apb(1'h1, 12'h228, 32'h3);
		rd(12'h248, 32'h1);
		rd(12'h244, 32'h3);
	endtask
	task automatic t_div;
		// divisor of 16, upper half of the bus word must be dropped
		apb(1'h1, 12'h240, 32'hFFFF0010);
		rd(12'h240, 32'h00000010);
		// twice the step with a divisor of 16: round(2^25 * 2 / 16)
		apb(1'h1, 12'h230, 32'h00400000);
		rd(12'h230, 32'h00400000);
	endtask
	task automatic t_midreset;
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("reset accum", 32'h0, accum_out);
		chk("reset single", 32'h0, {31'h0, single_chan});
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		rd(12'h240, 32'h0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#200us;
		err_total++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_rw;
		t_osc;
		t_div;
		t_midreset;
		tally_and_finish;
	end
endmodule // ncop_top_tb
